/* File: design/sideband_pkg.sv */
// Shared constants, encodings and carrier structs of the serializer sideband control block.
package sideband_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Clock and time.
   localparam int CLK_MHZ = 100;
   localparam int BC_MBPS_SLOW = 5;
   localparam int BC_MBPS_MID = 10;
   localparam int BC_MBPS_FAST = 20;
   // A back channel frame must arrive within this many line bits or the link is lost.
   localparam int BC_TIMEOUT_BITS = 64;
   localparam int WD_W = 11;

   ////////////////////////////////////////////////////////////////////////////////
   // Register offsets.
   localparam logic [7:0] ADDR_LINK_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_GPIO0_MODE = 8'h0d;
   localparam logic [7:0] ADDR_GPIO12_MODE = 8'h0e;
   localparam logic [7:0] ADDR_GPIO3_MODE = 8'h0f;
   localparam logic [7:0] ADDR_REGIO56_MODE = 8'h10;
   localparam logic [7:0] ADDR_REGIO78_MODE = 8'h11;
   localparam logic [7:0] ADDR_INPUT_RB = 8'h1c;
   localparam logic [7:0] ADDR_REGIO8_RB = 8'h1d;
   localparam logic [7:0] ADDR_INT_CTRL = 8'hc6;
   localparam logic [7:0] ADDR_INT_STATUS = 8'hc7;

   ////////////////////////////////////////////////////////////////////////////////
   // Field positions and reset values.
   localparam int LINK_DETECT_BIT = 0;
   localparam int BC_RATE_LSB = 1;
   localparam int INT_GLOBAL_BIT = 0;
   localparam int INT_REMOTE_BIT = 5;
   localparam int RB_REGIO_LSB = 5;
   localparam int RB_REGIO8_BIT = 0;
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] INT_CTRL_RST = 8'h00;
   localparam logic [7:0] READ_ZERO = 8'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // Mode nibble codes.
   localparam logic [3:0] NIB_OUT_LOW = 4'h1;
   localparam logic [3:0] NIB_OUT_HIGH = 4'h9;
   localparam logic [3:0] NIB_INPUT = 4'h3;
   localparam logic [3:0] NIB_BACK_OUT = 4'h5;

   typedef enum logic [1:0] {
      BC_RATE_5 = 2'b00,
      BC_RATE_10 = 2'b01,
      BC_RATE_20 = 2'b10
   } bc_rate_e;

   // Clock cycles per back channel line bit.
   function automatic logic [4:0] bit_cycles(input logic [1:0] rate);
      int mbps;
      mbps = BC_MBPS_SLOW;
      if (rate == BC_RATE_10) mbps = BC_MBPS_MID;
      if (rate == BC_RATE_20) mbps = BC_MBPS_FAST;
      return 5'(CLK_MHZ / mbps);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Carriers.
   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_s;

   typedef struct packed {
      logic valid;
      logic [7:0] rdata;
   } reg_rsp_s;

   typedef struct packed {
      logic valid;
      logic locked;
      logic [1:0] rate;
      logic downstream_interrupt_in_n_n;
      logic [3:0] gpio;
   } bc_s;

   typedef struct packed {
      logic [3:0] gpio_en;
      logic [3:0] gpio;
   } fwd_s;

   typedef struct packed {
      logic [7:0] mode_0d;
      logic [7:0] mode_0e;
      logic [7:0] mode_0f;
      logic [7:0] mode_10;
      logic [7:0] mode_11;
      logic [7:0] int_ctrl;
      logic rem_pend;
      logic rint_lvl;
      logic [WD_W-1:0] wd_cnt;
      logic link_up;
      logic link_detect;
      logic [1:0] bc_rate;
      logic [3:0] gpio_out;
      logic [3:0] gpio_oe_n;
      logic [3:0] regio_out;
      logic [3:0] regio_oe_n;
      logic [3:0] audio_ovr;
      fwd_s fwd;
      reg_rsp_s rsp;
      logic int_n;
      logic mirror;
      logic powered_down;
   } state_s;

endpackage

/* File: design/level_sync.sv */
// Two-flop synchroniser for asynchronous level inputs.
module level_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_reg;

   // The first stage feeds only the second, so a metastable value never fans out.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         meta_reg <= INIT;
         q <= INIT;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end

endmodule // level_sync

/* File: design/gpio_mode_decode.sv */
// Decoder of one GPIO mode nibble into pin drive and forwarding controls.
module gpio_mode_decode (
   input wire logic [3:0] mode,
   input wire logic link_capable,
   input wire logic remote_val,
   output logic drive_n,
   output logic drive_val,
   output logic forward_en
);

   // Unknown codes leave the pin undriven rather than guess a direction.
   always_comb begin
      drive_n = 1'b1;
      drive_val = 1'b0;
      forward_en = 1'b0;
      case (mode)
         sideband_pkg::NIB_OUT_LOW: begin
            drive_n = 1'b0;
         end
         sideband_pkg::NIB_OUT_HIGH: begin
            drive_n = 1'b0;
            drive_val = 1'b1;
         end
         sideband_pkg::NIB_INPUT: begin
            forward_en = link_capable;
         end
         sideband_pkg::NIB_BACK_OUT: begin
            drive_n = ~link_capable;
            drive_val = link_capable & remote_val;
         end
         default: begin
            drive_n = 1'b1;
         end
      endcase
   end

endmodule // gpio_mode_decode

/* File: design/serializer_sideband_control.sv */
// Sideband control of a video-link serializer: power-down, link fault, interrupts and GPIO.
//
// Summary of operation
// - Power-down low resets every control register.
// - Any link fault reads link detect zero.
// - All fault kinds share one status bit.
// - Active-low interrupt output, control and status registers.
// - Downstream interrupt falling edge pulls output low.
// - Reading interrupt status clears and releases output.
// - Mirror output follows downstream interrupt level.
// - Mirror output high without a link.
// - Link GPIO nibbles select forward or back.
// - Nibble codes drive low, high, or input.
// - Register-only GPIOs use same codes, readback.
// - Register GPIO mode overrides shared audio input.
// - Register-only GPIO state never crosses the link.
// - Back channel runs at 5, 10, 20 Mbps.
module serializer_sideband_control (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic power_down_n_pin,
   input wire logic [6:0] fault_pin,
   input wire sideband_pkg::reg_req_s reg_req,
   output sideband_pkg::reg_rsp_s reg_rsp,
   input wire sideband_pkg::bc_s bc,
   output sideband_pkg::fwd_s fwd,
   input wire logic [3:0] gpio_in,
   output logic [3:0] gpio_out,
   output logic [3:0] gpio_oe_n,
   input wire logic [3:0] regio_in,
   output logic [3:0] regio_out,
   output logic [3:0] regio_oe_n,
   output logic [3:0] audio_override,
   output logic interrupt_out_n,
   output logic remote_interrupt_mirror,
   output logic powered_down
);

   localparam sideband_pkg::state_s ST_RST = '{
      mode_0d: sideband_pkg::MODE_RST,
      mode_0e: sideband_pkg::MODE_RST,
      mode_0f: sideband_pkg::MODE_RST,
      mode_10: sideband_pkg::MODE_RST,
      mode_11: sideband_pkg::MODE_RST,
      int_ctrl: sideband_pkg::INT_CTRL_RST,
      rint_lvl: 1'b1,
      gpio_oe_n: 4'hf,
      regio_oe_n: 4'hf,
      int_n: 1'b1,
      mirror: 1'b1,
      default: '0
   };

   localparam int WD_W_L = sideband_pkg::WD_W;

   sideband_pkg::state_s st;
   sideband_pkg::state_s nx;
   logic pd_n_sync;
   logic [6:0] fault_sync;
   logic [7:0] pin_sync;
   logic [7:0] mode_0d_w;
   logic [7:0] mode_0e_w;
   logic [7:0] mode_0f_w;
   logic [7:0] mode_10_w;
   logic [7:0] mode_11_w;
   logic [7:0] int_ctrl_w;
   logic [31:0] nib_all;
   logic [7:0] dec_drive_n;
   logic [7:0] dec_val;
   logic [7:0] dec_fwd;
   logic link_up_w;
   logic rint_lvl_w;
   logic rem_set;
   logic isr_read;
   logic [WD_W_L-1:0] wd_limit;
   logic [7:0] rdata_w;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers.

   level_sync #(.W(1), .INIT(1'b0)) u_pd_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .d(power_down_n_pin),
      .q(pd_n_sync)
   );

   level_sync #(.W(7), .INIT(7'h00)) u_fault_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .d(fault_pin),
      .q(fault_sync)
   );

   level_sync #(.W(8), .INIT(8'h00)) u_pin_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .d({regio_in, gpio_in}),
      .q(pin_sync)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Register writes and mode decode.

   always_comb begin
      mode_0d_w = st.mode_0d;
      mode_0e_w = st.mode_0e;
      mode_0f_w = st.mode_0f;
      mode_10_w = st.mode_10;
      mode_11_w = st.mode_11;
      int_ctrl_w = st.int_ctrl;
      if (reg_req.valid && reg_req.write) begin
         case (reg_req.addr)
            sideband_pkg::ADDR_GPIO0_MODE: mode_0d_w = reg_req.wdata;
            sideband_pkg::ADDR_GPIO12_MODE: mode_0e_w = reg_req.wdata;
            sideband_pkg::ADDR_GPIO3_MODE: mode_0f_w = reg_req.wdata;
            sideband_pkg::ADDR_REGIO56_MODE: mode_10_w = reg_req.wdata;
            sideband_pkg::ADDR_REGIO78_MODE: mode_11_w = reg_req.wdata;
            sideband_pkg::ADDR_INT_CTRL: int_ctrl_w = reg_req.wdata;
            default: begin
            end
         endcase
      end
   end

   assign nib_all = {mode_11_w, mode_10_w, mode_0f_w[3:0], mode_0e_w, mode_0d_w[3:0]};

   // Register-only GPIOs are decoded without link capability, so they never forward.
   for (genvar i = 0; i < 8; i++) begin : g_dec
      gpio_mode_decode u_dec (
         .mode(nib_all[4*i +: 4]),
         .link_capable(i < 4),
         .remote_val((i < 4) ? bc.gpio[i % 4] : 1'b0),
         .drive_n(dec_drive_n[i]),
         .drive_val(dec_val[i]),
         .forward_en(dec_fwd[i])
      );
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Back channel watchdog and remote interrupt.

   assign wd_limit = WD_W_L'(sideband_pkg::BC_TIMEOUT_BITS * int'(sideband_pkg::bit_cycles(bc.rate)));
   assign link_up_w = bc.locked && (bc.valid || (st.wd_cnt < wd_limit));
   assign rint_lvl_w = !link_up_w ? 1'b1 : (bc.valid ? bc.downstream_interrupt_in_n_n : st.rint_lvl);
   // A falling edge of the downstream level only counts while the path is enabled.
   assign rem_set = link_up_w && bc.valid && st.rint_lvl && !bc.downstream_interrupt_in_n_n
                    && st.int_ctrl[sideband_pkg::INT_GLOBAL_BIT]
                    && st.int_ctrl[sideband_pkg::INT_REMOTE_BIT];
   assign isr_read = reg_req.valid && !reg_req.write
                     && (reg_req.addr == sideband_pkg::ADDR_INT_STATUS);

   ////////////////////////////////////////////////////////////////////////////////
   // Register reads.

   always_comb begin
      rdata_w = sideband_pkg::READ_ZERO;
      case (reg_req.addr)
         sideband_pkg::ADDR_LINK_STATUS: begin
            rdata_w[sideband_pkg::LINK_DETECT_BIT] = st.link_detect;
            rdata_w[sideband_pkg::BC_RATE_LSB +: 2] = st.bc_rate;
         end
         sideband_pkg::ADDR_GPIO0_MODE: rdata_w = st.mode_0d;
         sideband_pkg::ADDR_GPIO12_MODE: rdata_w = st.mode_0e;
         sideband_pkg::ADDR_GPIO3_MODE: rdata_w = st.mode_0f;
         sideband_pkg::ADDR_REGIO56_MODE: rdata_w = st.mode_10;
         sideband_pkg::ADDR_REGIO78_MODE: rdata_w = st.mode_11;
         sideband_pkg::ADDR_INPUT_RB: begin
            rdata_w[3:0] = pin_sync[3:0];
            rdata_w[sideband_pkg::RB_REGIO_LSB +: 3] = pin_sync[6:4];
         end
         sideband_pkg::ADDR_REGIO8_RB: rdata_w[sideband_pkg::RB_REGIO8_BIT] = pin_sync[7];
         sideband_pkg::ADDR_INT_CTRL: rdata_w = st.int_ctrl;
         sideband_pkg::ADDR_INT_STATUS: begin
            rdata_w[sideband_pkg::INT_REMOTE_BIT] = st.rem_pend;
            rdata_w[sideband_pkg::INT_GLOBAL_BIT] = ~st.int_n;
         end
         default: rdata_w = sideband_pkg::READ_ZERO;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next state.

   always_comb begin
      nx = st;
      nx.mode_0d = mode_0d_w;
      nx.mode_0e = mode_0e_w;
      nx.mode_0f = mode_0f_w;
      nx.mode_10 = mode_10_w;
      nx.mode_11 = mode_11_w;
      nx.int_ctrl = int_ctrl_w;
      nx.powered_down = 1'b0;
      nx.link_up = link_up_w;
      nx.bc_rate = bc.rate;
      nx.wd_cnt = (bc.valid || !bc.locked) ? '0
                  : ((st.wd_cnt < wd_limit) ? st.wd_cnt + 1'b1 : st.wd_cnt);
      // Every fault kind collapses into the one detect bit; the kind is not kept.
      nx.link_detect = link_up_w && (fault_sync == 7'h00);
      nx.rint_lvl = rint_lvl_w;
      nx.mirror = rint_lvl_w;
      // A new edge in the same cycle as the status read stays pending.
      nx.rem_pend = rem_set || (st.rem_pend && !isr_read);
      nx.int_n = ~(nx.rem_pend && int_ctrl_w[sideband_pkg::INT_GLOBAL_BIT]
                   && int_ctrl_w[sideband_pkg::INT_REMOTE_BIT]);
      nx.gpio_out = dec_val[3:0];
      nx.gpio_oe_n = dec_drive_n[3:0];
      nx.regio_out = dec_val[7:4];
      nx.regio_oe_n = dec_drive_n[7:4];
      // Only the drive and input codes claim the shared pin; the back channel code is not a mode here.
      nx.audio_ovr = ~dec_drive_n[7:4] | {nib_all[31:28] == sideband_pkg::NIB_INPUT,
                                          nib_all[27:24] == sideband_pkg::NIB_INPUT,
                                          nib_all[23:20] == sideband_pkg::NIB_INPUT,
                                          nib_all[19:16] == sideband_pkg::NIB_INPUT};
      nx.fwd.gpio_en = dec_fwd[3:0];
      nx.fwd.gpio = pin_sync[3:0] & dec_fwd[3:0];
      nx.rsp.valid = reg_req.valid;
      nx.rsp.rdata = (reg_req.valid && !reg_req.write) ? rdata_w : sideband_pkg::READ_ZERO;
      if (!pd_n_sync) begin
         nx = ST_RST;
         nx.powered_down = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st <= ST_RST;
      end else if (ce) begin
         st <= nx;
      end
   end

   assign reg_rsp = st.rsp;
   assign fwd = st.fwd;
   assign gpio_out = st.gpio_out;
   assign gpio_oe_n = st.gpio_oe_n;
   assign regio_out = st.regio_out;
   assign regio_oe_n = st.regio_oe_n;
   assign audio_override = st.audio_ovr;
   assign interrupt_out_n = st.int_n;
   assign remote_interrupt_mirror = st.mirror;
   assign powered_down = st.powered_down;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.

   a_pd_resets_regs: assert property (@(posedge ref_clk) disable iff (rst)
      (ce && !pd_n_sync) |=> (st.mode_0d == sideband_pkg::MODE_RST && st.int_ctrl ==
      sideband_pkg::INT_CTRL_RST && interrupt_out_n && powered_down && gpio_oe_n == 4'hf))
      else $error("power-down did not restore register defaults");

   a_fault_drops_detect: assert property (@(posedge ref_clk) disable iff (rst)
      (ce && fault_sync != 7'h00) |=> !st.link_detect)
      else $error("link detect stayed set during a fault");

   a_edge_asserts_int: assert property (@(posedge ref_clk) disable iff (rst || !pd_n_sync)
      (ce && rem_set) |=> !interrupt_out_n)
      else $error("remote interrupt edge did not pull output low");

   a_isr_read_release: assert property (@(posedge ref_clk) disable iff (rst || !pd_n_sync)
      (ce && isr_read && !rem_set) |=> (interrupt_out_n && !st.rem_pend))
      else $error("status read did not release interrupt");

   a_mirror_follows: assert property (@(posedge ref_clk) disable iff (rst || !pd_n_sync)
      (ce && bc.valid && bc.locked) |=> (remote_interrupt_mirror == $past(bc.downstream_interrupt_in_n_n)))
      else $error("mirror did not follow downstream interrupt");

   a_mirror_no_link: assert property (@(posedge ref_clk) disable iff (rst)
      (ce && !bc.locked) |=> remote_interrupt_mirror)
      else $error("mirror low without a link");

   a_gpio_drive_low: assert property (@(posedge ref_clk) disable iff (rst || !pd_n_sync)
      (ce && reg_req.valid && reg_req.write && reg_req.addr == sideband_pkg::ADDR_GPIO0_MODE
      && reg_req.wdata[3:0] == sideband_pkg::NIB_OUT_LOW) |=> (!gpio_oe_n[0] && !gpio_out[0]))
      else $error("gpio0 not driven low after mode write");

   a_regio_not_forwarded: assert property (@(posedge ref_clk) disable iff (rst || !pd_n_sync)
      (ce && reg_req.valid && reg_req.write && reg_req.addr == sideband_pkg::ADDR_REGIO56_MODE
      && $stable(pin_sync) && $stable(st.mode_0d)) |=> $stable(fwd.gpio_en))
      else $error("register gpio write changed forward channel");

endmodule // serializer_sideband_control

/* File: tb/deser_model.sv */
// Behavioural back channel decoder of the paired deserializer.
module deser_model (
   input wire logic ref_clk,
   input wire logic run,
   input wire logic mute,
   input wire logic [1:0] rate,
   input wire logic interrupt_out_n_n,
   input wire logic [3:0] gpio_bc,
   output sideband_pkg::bc_s bc
);
   timeunit 1ns;
   timeprecision 100ps;
   int cnt = 0;
   initial bc = '0;
   ////////////////////////////////////////
   // A frame every 16 line bits keeps well inside the loss limit.
   always @(posedge ref_clk) begin
      #1;
      bc.valid = 1'b0;
      bc.locked = run;
      bc.rate = rate;
      if (!run) begin
         // A released link shows flipped levels, never a stale copy.
         bc.downstream_interrupt_in_n_n = ~bc.downstream_interrupt_in_n_n;
         bc.gpio = ~bc.gpio;
         cnt = 0;
      end else if (!mute && ++cnt >= 16 * (100 / (5 << rate))) begin
         cnt = 0;
         bc.valid = 1'b1;
         bc.downstream_interrupt_in_n_n = interrupt_out_n_n;
         bc.gpio = gpio_bc;
      end
   end
endmodule // deser_model

/* File: tb/serializer_sideband_control_bench.sv */
// Self-checking bench of the serializer sideband control block.
module serializer_sideband_control_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk, rst, power_down_n_pin, run, mute, interrupt_out_n_n;
   logic [1:0] rate;
   logic [3:0] gpio_bc, gpio_ext, regio_ext, gpio_out, gpio_oe_n;
   logic [3:0] regio_out, regio_oe_n, audio_override, gpio_wire, regio_wire;
   logic [6:0] fault_pin;
   logic interrupt_out_n, remote_interrupt_mirror, powered_down;
   sideband_pkg::reg_req_s reg_req;
   sideband_pkg::reg_rsp_s reg_rsp;
   sideband_pkg::bc_s bc;
   sideband_pkg::fwd_s fwd;
   int errors, checks, seed, i, k;
   logic [7:0] mode [5];
   logic [7:0] rd;
   logic [3:0] codes [5] = '{4'h1, 4'h9, 4'h3, 4'h5, 4'h0};
   // The pins are resolved here from the serializer's enables alone; the external value drives when they are off.
   assign gpio_wire = (gpio_oe_n & gpio_ext) | (~gpio_oe_n & gpio_out);
   assign regio_wire = (regio_oe_n & regio_ext) | (~regio_oe_n & regio_out);
   serializer_sideband_control serializer_sideband_control_i (
      .ref_clk(ref_clk), .rst(rst), .ce(1'b1), .power_down_n_pin(power_down_n_pin),
      .fault_pin(fault_pin), .reg_req(reg_req), .reg_rsp(reg_rsp), .bc(bc), .fwd(fwd),
      .gpio_in(gpio_wire), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
      .regio_in(regio_wire), .regio_out(regio_out), .regio_oe_n(regio_oe_n),
      .audio_override(audio_override), .interrupt_out_n(interrupt_out_n),
      .remote_interrupt_mirror(remote_interrupt_mirror), .powered_down(powered_down));
   deser_model deser_model_i (
      .ref_clk(ref_clk), .run(run), .mute(mute), .rate(rate), .interrupt_out_n_n(interrupt_out_n_n),
      .gpio_bc(gpio_bc), .bc(bc));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   ////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic reg_acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      #1;
      reg_req = '{valid: 1'b1, write: wr, addr: a, wdata: d};
      @(posedge ref_clk);
      #1;
      reg_req.valid = 1'b0;
      rd = reg_rsp.rdata;
      chk({7'h0, reg_rsp.valid}, 8'h01, "response strobe");
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      reg_acc(1'b0, a, 8'h00);
      chk(rd & m, e & m, $sformatf("register %h", a));
   endtask
   task automatic outs(input logic [1:0] e, input string what);
      chk({6'h0, interrupt_out_n, remote_interrupt_mirror}, {6'h0, e}, what);
   endtask
   task automatic frame_wait();
      int n;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (bc.valid !== 1'b1 && n < 2000);
      #1;
      if (n >= 2000) chk(8'h00, 8'h01, "frame");
   endtask
   // Expected pin behaviour is worked out lane by lane from the written nibbles.
   task automatic check_pins();
      logic [7:0] eoe, ew, ext;
      logic [3:0] n, fen;
      logic drv;
      ext = {regio_ext, gpio_ext};
      for (int l = 0; l < 8; l++) begin
         n = (l == 2 || l == 5 || l == 7) ? mode[(l < 4) ? 1 : 3 + (l - 4) / 2][7:4]
            : mode[(l < 4) ? (l + 1) / 2 : 3 + (l - 4) / 2][3:0];
         drv = (n == 4'h1) || (n == 4'h9) || (n == 4'h5 && l < 4);
         eoe[l] = !drv;
         ew[l] = drv ? ((n == 4'h9) || (n == 4'h5 && gpio_bc[l % 4])) : ext[l];
         if (l < 4) fen[l] = (n == 4'h3);
         else fen[l - 4] = (n == 4'h1 || n == 4'h9 || n == 4'h3);
         if (l == 3) chk({4'h0, fwd.gpio_en}, {4'h0, fen}, "forward enables");
      end
      chk({regio_oe_n, gpio_oe_n}, eoe, "enables");
      chk({regio_wire, gpio_wire}, ew, "pin levels");
      chk({4'h0, audio_override}, {4'h0, fen}, "audio override");
      chk({4'h0, fwd.gpio}, {4'h0, fwd.gpio_en & ew[3:0]}, "forward lanes");
      rd_chk(sideband_pkg::ADDR_INPUT_RB, {ew[6:4], 1'b0, ew[3:0]}, 8'hef);
      rd_chk(sideband_pkg::ADDR_REGIO8_RB, {7'h0, ew[7]}, 8'h01);
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      #200000;
      errors++;
      $display("ERROR %0t: watchdog expired", $time);
      final_report();
   end
   ////////////////////////////////////////
   initial begin
      {errors, checks, seed} = {32'd0, 32'd0, 32'd2257};
      {rst, power_down_n_pin, run, mute, interrupt_out_n_n, rate} = 7'b1100110;
      {gpio_bc, gpio_ext, regio_ext, fault_pin} = '0;
      reg_req = '0;
      repeat (5) @(posedge ref_clk);
      #1 rst = 1'b0;
      repeat (6) @(posedge ref_clk);
      #1 outs(2'b11, "idle outputs");
      for (i = 0; i < 5; i++) rd_chk(8'h0d + 8'(i), 8'h00, 8'hff);
      rd_chk(sideband_pkg::ADDR_INT_CTRL, 8'h00, 8'hff);
      reg_acc(1'b1, 8'h55, 8'hff);
      rd_chk(8'h55, 8'h00, 8'hff);
      rd_chk(sideband_pkg::ADDR_LINK_STATUS, 8'h00, 8'h01);
      $display("test reset done");
      run = 1'b1;
      for (i = 0; i < 3; i++) begin
         rate = i[1:0];
         repeat (700) @(posedge ref_clk);
         rd_chk(sideband_pkg::ADDR_LINK_STATUS, {5'h0, i[1:0], 1'b1}, 8'h07);
      end
      for (i = 0; i < 8; i++) begin
         fault_pin = 7'(i < 7 ? 1 << i : 0);
         repeat (4) @(posedge ref_clk);
         rd_chk(sideband_pkg::ADDR_LINK_STATUS, {7'h0, i == 7}, 8'h01);
      end
      $display("test link done");
      reg_acc(1'b1, sideband_pkg::ADDR_INT_CTRL, 8'h21);
      for (k = 0; k < 2; k++) begin
         interrupt_out_n_n = 1'b1;
         frame_wait();
         outs(2'b11, "high level");
         interrupt_out_n_n = 1'b0;
         frame_wait();
         outs(2'b00, "remote interrupt");
         rd_chk(sideband_pkg::ADDR_INT_STATUS, 8'h21, 8'h21);
         outs(2'b10, "released");
         rd_chk(sideband_pkg::ADDR_INT_STATUS, 8'h00, 8'h21);
         frame_wait();
         outs(2'b10, "no new edge");
      end
      reg_acc(1'b1, sideband_pkg::ADDR_INT_CTRL, 8'h20);
      interrupt_out_n_n = 1'b1;
      frame_wait();
      interrupt_out_n_n = 1'b0;
      frame_wait();
      reg_acc(1'b1, sideband_pkg::ADDR_INT_CTRL, 8'h21);
      outs(2'b10, "edge dropped");
      frame_wait();
      mute = 1'b1;
      repeat (250) @(posedge ref_clk);
      outs(2'b10, "before loss");
      repeat (100) @(posedge ref_clk);
      outs(2'b11, "frames lost");
      rd_chk(sideband_pkg::ADDR_LINK_STATUS, 8'h00, 8'h01);
      mute = 1'b0;
      run = 1'b0;
      repeat (4) @(posedge ref_clk);
      outs(2'b11, "unlocked");
      $display("test interrupt done");
      run = 1'b1;
      gpio_bc = 4'($random(seed));
      frame_wait();
      frame_wait();
      for (k = 0; k < 8; k++) begin
         for (i = 0; i < 5; i++) begin
            mode[i][3:0] = (k < 5) ? codes[k] : codes[{$random(seed)} % 5];
            mode[i][7:4] = (k < 5) ? codes[k] : codes[{$random(seed)} % 5];
            reg_acc(1'b1, 8'h0d + 8'(i), mode[i]);
            rd_chk(8'h0d + 8'(i), mode[i], (i == 0 || i == 2) ? 8'h0f : 8'hff);
         end
         gpio_ext = 4'($random(seed));
         regio_ext = 4'($random(seed));
         repeat (4) @(posedge ref_clk);
         check_pins();
      end
      $display("test gpio done");
      power_down_n_pin = 1'b0;
      // The low time is far below the real minimum; the block does not count it.
      repeat (20) @(posedge ref_clk);
      chk({powered_down, regio_oe_n, gpio_oe_n}, 9'h1ff, "powered down");
      power_down_n_pin = 1'b1;
      repeat (6) @(posedge ref_clk);
      for (i = 0; i < 5; i++) rd_chk(8'h0d + 8'(i), 8'h00, 8'hff);
      rd_chk(sideband_pkg::ADDR_INT_CTRL, 8'h00, 8'hff);
      $display("test power down done");
      final_report();
   end
endmodule // serializer_sideband_control_bench
